// ### hw/charger_cfg_pkg.sv
/*
  Constants for the charger input configuration register bank: serial slave
  address, register indices, field positions, reset values and the current
  cap codes chosen after source detection.
  Assumes nothing of its surroundings.
*/
package charger_cfg_pkg;

    // Serial slave address (7 bits)
    localparam logic [6:0] DEVICE_ADDR = 7'h6b;

    // Register indices
    localparam logic [7:0] INPUT_SOURCE_CONTROL_IDX   = 8'h00;
    localparam logic [7:0] POWER_ON_CONFIGURATION_IDX = 8'h01;
    localparam logic [7:0] LAST_RW_IDX                = 8'h07;
    localparam logic [7:0] SYSTEM_STATUS_IDX          = 8'h08;
    localparam logic [7:0] FAULT_STATUS_IDX           = 8'h09;
    localparam logic [7:0] PART_INFO_IDX              = 8'h0a;
    localparam logic [7:0] LAST_IDX                   = 8'h0a;
    localparam int         RW_COUNT                   = 8;

    // Reset values of the writable registers, index 0 to 7
    localparam logic [7:0] RESET_VAL [0:RW_COUNT-1] = '{
        8'h30, 8'h1b, 8'h60, 8'h11, 8'hb2, 8'h9a, 8'h03, 8'h4b
    };

    // Input source control fields
    localparam int HIZ_BIT     = 7;
    localparam int VFLOOR_MSB  = 6;
    localparam int VFLOOR_LSB  = 3;
    localparam int CAP_MSB     = 2;
    localparam int CAP_LSB     = 0;

    // Power-on configuration fields
    localparam int REG_RESET_BIT = 7;
    localparam int WD_RESET_BIT  = 6;
    localparam int CHGCFG_MSB    = 5;
    localparam int CHGCFG_LSB    = 4;
    localparam int SYSMIN_MSB    = 3;
    localparam int SYSMIN_LSB    = 1;

    // Input current cap codes set by source detection
    localparam logic [2:0] CAP_SDP_BOOST_LOW  = 3'b000;
    localparam logic [2:0] CAP_SDP_BOOST_HIGH = 3'b010;
    localparam logic [2:0] CAP_DEDICATED      = 3'b101;

    // Detected source kinds
    typedef enum logic [1:0] {
        SRC_NONE      = 2'b00,
        SRC_STANDARD  = 2'b01,
        SRC_DEDICATED = 2'b10,
        SRC_CHARGING  = 2'b11
    } source_kind_t;

    // Serial engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_REG   = 3'b010,
        ST_WRITE = 3'b011,
        ST_ACK   = 3'b100,
        ST_READ  = 3'b101,
        ST_RACK  = 3'b110
    } serial_state_t;

endpackage

// ### hw/charger_input_config_regs.sv
/*
  Register bank for the input source control and power-on configuration of
  a single cell charger, reached through a two-wire serial slave port.
  Assumes: clock of 125 MHz, serial clock and data arrive asynchronously from
  open-drain pins with external pull-ups; source detection and watchdog
  expiry come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module charger_input_config_regs
    import charger_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Serial pins, open drain
    input  wire logic       sclIn,
    output logic            sclOut,
    output logic            sclOe,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // Source detection and mode
    input  wire logic       boostPin,
    input  wire logic       sourceDetectDone,
    input  wire logic [1:0] sourceKind,
    input  wire logic       watchdogExpired,
    // Read-only status contents
    input  wire logic [7:0] systemStatus,
    input  wire logic [7:0] faultStatus,
    input  wire logic [7:0] partInfo,
    // Converter controls
    output logic            inputHighImpedanceEnable,
    output logic [3:0]      inputVoltageFloor,
    output logic [2:0]      inputCurrentCap,
    output logic [1:0]      chargeConfigSelect,
    output logic [2:0]      minimumSystemVoltage,
    output logic            watchdogRestart,
    output logic            hostMode
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus events
    logic          sclMetaQ, sclSyncQ, sclPrevQ;
    logic          sdaMetaQ, sdaSyncQ, sdaPrevQ;
    logic          boostMetaQ, boostSyncQ;
    logic          sclRise, sclFall, startSeen, stopSeen;

    always_ff @(posedge clock) begin
        if (reset) begin
            sclMetaQ   <= 1'b1;
            sclSyncQ   <= 1'b1;
            sclPrevQ   <= 1'b1;
            sdaMetaQ   <= 1'b1;
            sdaSyncQ   <= 1'b1;
            sdaPrevQ   <= 1'b1;
            boostMetaQ <= 1'b0;
            boostSyncQ <= 1'b0;
        end else begin
            sclMetaQ   <= sclIn;
            sclSyncQ   <= sclMetaQ;
            sclPrevQ   <= sclSyncQ;
            sdaMetaQ   <= sdaIn;
            sdaSyncQ   <= sdaMetaQ;
            sdaPrevQ   <= sdaSyncQ;
            boostMetaQ <= boostPin;
            boostSyncQ <= boostMetaQ;
        end
    end

    assign sclRise   = sclSyncQ & ~sclPrevQ;
    assign sclFall   = ~sclSyncQ & sclPrevQ;
    assign startSeen = sclSyncQ & sclPrevQ & sdaPrevQ & ~sdaSyncQ;
    assign stopSeen  = sclSyncQ & sclPrevQ & ~sdaPrevQ & sdaSyncQ;

    ////////////////////////////////////////////////////////////////////////
    // Register storage and read decode
    logic [7:0]    regsQ [0:RW_COUNT-1];
    logic [7:0]    idxQ;
    logic [7:0]    readByte;
    logic [7:0]    rxByte;
    logic [7:0]    shiftQ;
    serial_state_t stateQ, afterQ;
    logic [3:0]    bitCntQ;
    logic          sdaOeQ, ackOnQ;
    logic          byteDone, wrEn, regResetReq, capFromDetect;
    logic [2:0]    detectCap;

    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        if (idx <= LAST_RW_IDX) begin
            read_reg = regsQ[idx[2:0]];
        end else if (idx == SYSTEM_STATUS_IDX) begin
            read_reg = systemStatus;
        end else if (idx == FAULT_STATUS_IDX) begin
            read_reg = faultStatus;
        end else if (idx == PART_INFO_IDX) begin
            read_reg = partInfo;
        end else begin
            read_reg = 8'h00;
        end
    endfunction

    // Process form so that the decode follows register and status changes
    always_comb readByte = read_reg(idxQ);
    assign rxByte      = {shiftQ[6:0], sdaSyncQ};
    assign byteDone    = sclRise && (bitCntQ == 4'h7);
    assign wrEn        = byteDone && (stateQ == ST_WRITE) && !startSeen && !stopSeen
                         && (idxQ <= LAST_IDX);
    assign regResetReq = wrEn && (idxQ == POWER_ON_CONFIGURATION_IDX)
                         && rxByte[REG_RESET_BIT];

    always_comb begin
        detectCap     = CAP_DEDICATED;
        capFromDetect = sourceDetectDone;
        case (sourceKind)
            SRC_STANDARD:  detectCap = boostSyncQ ? CAP_SDP_BOOST_HIGH
                                                  : CAP_SDP_BOOST_LOW;
            SRC_DEDICATED: detectCap = CAP_DEDICATED;
            SRC_CHARGING:  detectCap = CAP_DEDICATED;
            default:       capFromDetect = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset || regResetReq) begin
            for (int i = 0; i < RW_COUNT; i++) begin
                regsQ[i] <= RESET_VAL[i];
            end
        end else begin
            if (wrEn && idxQ <= LAST_RW_IDX) begin
                regsQ[idxQ[2:0]] <= rxByte;
                if (idxQ == POWER_ON_CONFIGURATION_IDX) begin
                    regsQ[1][REG_RESET_BIT] <= 1'b0;
                    regsQ[1][WD_RESET_BIT]  <= 1'b0;
                end
            end
            if (capFromDetect && !(wrEn && idxQ == INPUT_SOURCE_CONTROL_IDX)) begin
                regsQ[0][CAP_MSB:CAP_LSB] <= detectCap;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode and watchdog restart
    always_ff @(posedge clock) begin
        if (reset) begin
            hostMode        <= 1'b0;
            watchdogRestart <= 1'b0;
        end else begin
            watchdogRestart <= wrEn && (idxQ == POWER_ON_CONFIGURATION_IDX)
                               && rxByte[WD_RESET_BIT];
            if (wrEn) begin
                hostMode <= 1'b1;
            end else if (watchdogExpired) begin
                hostMode <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial slave engine
    always_ff @(posedge clock) begin
        if (reset) begin
            stateQ  <= ST_IDLE;
            afterQ  <= ST_IDLE;
            bitCntQ <= 4'h0;
            shiftQ  <= 8'h00;
            sdaOeQ  <= 1'b0;
            ackOnQ  <= 1'b0;
            idxQ    <= 8'h00;
        end else if (startSeen) begin
            stateQ  <= ST_ADDR;
            bitCntQ <= 4'h0;
            sdaOeQ  <= 1'b0;
            ackOnQ  <= 1'b0;
        end else if (stopSeen) begin
            stateQ <= ST_IDLE;
            sdaOeQ <= 1'b0;
            ackOnQ <= 1'b0;
        end else begin
            case (stateQ)
                ST_ADDR, ST_REG, ST_WRITE: begin
                    if (sclRise) begin
                        shiftQ  <= rxByte;
                        bitCntQ <= bitCntQ + 4'h1;
                    end
                    if (byteDone) begin
                        bitCntQ <= 4'h0;
                        stateQ  <= ST_ACK;
                        if (stateQ == ST_ADDR) begin
                            if (rxByte[7:1] != DEVICE_ADDR) begin
                                stateQ <= ST_IDLE;
                            end
                            afterQ <= rxByte[0] ? ST_READ : ST_REG;
                        end else if (stateQ == ST_REG) begin
                            if (rxByte > LAST_IDX) begin
                                stateQ <= ST_IDLE;
                            end
                            idxQ   <= rxByte;
                            afterQ <= ST_WRITE;
                        end else begin
                            if (idxQ > LAST_IDX) begin
                                stateQ <= ST_IDLE;
                            end
                            idxQ   <= idxQ + 8'h01;
                            afterQ <= ST_WRITE;
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        if (!ackOnQ) begin
                            sdaOeQ <= 1'b1;
                            ackOnQ <= 1'b1;
                        end else begin
                            ackOnQ <= 1'b0;
                            stateQ <= afterQ;
                            if (afterQ == ST_READ) begin
                                sdaOeQ  <= ~readByte[7];
                                bitCntQ <= 4'h1;
                            end else begin
                                sdaOeQ <= 1'b0;
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (sclFall) begin
                        if (bitCntQ != 4'h8) begin
                            sdaOeQ  <= ~readByte[~bitCntQ[2:0]];
                            bitCntQ <= bitCntQ + 4'h1;
                        end else begin
                            sdaOeQ <= 1'b0;
                            stateQ <= ST_RACK;
                        end
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        if (sdaSyncQ) begin
                            stateQ <= ST_IDLE;
                        end else begin
                            idxQ    <= idxQ + 8'h01;
                            bitCntQ <= 4'h0;
                            stateQ  <= ST_READ;
                        end
                    end
                end
                default: stateQ <= ST_IDLE;
            endcase
        end
    end

    assign sdaOe  = sdaOeQ;
    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;
    assign sclOe  = 1'b0;

    assign inputHighImpedanceEnable = regsQ[0][HIZ_BIT];
    assign inputVoltageFloor        = regsQ[0][VFLOOR_MSB:VFLOOR_LSB];
    assign inputCurrentCap          = regsQ[0][CAP_MSB:CAP_LSB];
    assign chargeConfigSelect       = regsQ[1][CHGCFG_MSB:CHGCFG_LSB];
    assign minimumSystemVoltage     = regsQ[1][SYSMIN_MSB:SYSMIN_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    reset_src_value_a: assert property ($fell(reset) |-> regsQ[0] == RESET_VAL[0]
                                        && regsQ[1] == RESET_VAL[1])
        else $error("reset values wrong");
    reg_reset_reload_a: assert property (regResetReq |=> regsQ[0] == RESET_VAL[0]
                                         && regsQ[1] == RESET_VAL[1])
        else $error("register reset did not reload defaults");
    strobes_clear_a: assert property (regsQ[1][7:6] == 2'b00)
        else $error("self-clearing bits held a one");
    wd_restart_cause_a: assert property (watchdogRestart |-> $past(wrEn)
                                         && $past(idxQ) == POWER_ON_CONFIGURATION_IDX)
        else $error("watchdog restart without cause");
    ro_write_a: assert property (wrEn && idxQ > LAST_RW_IDX && !capFromDetect
                                 |=> $stable(regsQ[0]) && $stable(regsQ[1]))
        else $error("read-only write changed a register");
    host_mode_a: assert property (wrEn |=> hostMode)
        else $error("write did not enter host mode");
    bad_index_a: assert property (byteDone && stateQ == ST_REG && rxByte > LAST_IDX && !startSeen
                                  && !stopSeen |=> stateQ == ST_IDLE ##1 !sdaOe)
        else $error("undefined index not refused");
    addr_ack_a: assert property (byteDone && stateQ == ST_ADDR && rxByte[7:1] == DEVICE_ADDR
                                 && !startSeen && !stopSeen |=> stateQ == ST_ACK)
        else $error("own address not acknowledged");
    detect_cap_a: assert property (capFromDetect && !wrEn && sourceKind == SRC_DEDICATED
                                   |=> inputCurrentCap == CAP_DEDICATED)
        else $error("detected cap not applied");

    write_seen_c: cover property (wrEn && idxQ == INPUT_SOURCE_CONTROL_IDX);
    read_seen_c:  cover property (stateQ == ST_RACK ##[1:200] stateQ == ST_READ);
    nack_seen_c:  cover property (byteDone && stateQ == ST_REG && rxByte > LAST_IDX);

endmodule // charger_input_config_regs

`default_nettype wire

// ### verif/serial_host_model.sv
/*
  Serial host model: drives the clock and data lines open drain, one bit per
  20 system clocks (160 ns), and reads the data line back.
  Assumes the bench resolves both lines with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
    // Clock
    input  wire logic clock,
    // Lines
    input  wire logic sdaLine,
    output logic      sclDrv,
    output logic      sdaDrv
);
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Clock stays high between frames; works as start and repeated start
    task automatic start_bit();
        tick(5);
        sdaDrv = 1'b1;
        tick(5);
        sclDrv = 1'b1;
        tick(5);
        sdaDrv = 1'b0;
        tick(5);
        sclDrv = 1'b0;
    endtask

    task automatic stop_bit();
        tick(5);
        sdaDrv = 1'b0;
        tick(5);
        sclDrv = 1'b1;
        tick(5);
        sdaDrv = 1'b1;
        tick(5);
    endtask

    // Data changes only mid-low; sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        tick(5);
        sdaDrv = b;
        tick(5);
        sclDrv = 1'b1;
        tick(5);
        r = sdaLine;
        tick(5);
        sclDrv = 1'b0;
    endtask

    // Most significant bit first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] tx, input logic ackOut,
                           output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ackOut, ack);
    endtask
endmodule // serial_host_model

`default_nettype wire

// ### verif/tb_top.sv
/*
  Self-checking bench for the charger configuration register bank.
  Assumes the serial host model and pull-ups on both serial lines.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import charger_cfg_pkg::*;
    logic        clock, reset, boostPin, detDone, wdExp, sclDrv, sdaDrv;
    logic        sclOut, sclOe, sdaOut, sdaOe, hiz, restart, hostMode;
    logic [1:0]  kind, chgCfg;
    logic [3:0]  vFloor;
    logic [2:0]  cap, sysMin;
    logic [7:0]  sysSt, fltSt, part, rx, r8, m [0:10];
    logic [31:0] seed;
    logic [7:0]  q [$];
    int          badCount, comparisons, wdCount, cycles, w0;
    wire logic   sclLine = sclDrv & ~(sclOe & ~sclOut);
    wire logic   sdaLine = sdaDrv & ~(sdaOe & ~sdaOut);

    charger_input_config_regs u_dut (.clock(clock), .reset(reset),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .boostPin(boostPin),
        .sourceDetectDone(detDone), .sourceKind(kind), .watchdogExpired(wdExp),
        .systemStatus(sysSt), .faultStatus(fltSt), .partInfo(part),
        .inputHighImpedanceEnable(hiz), .inputVoltageFloor(vFloor),
        .inputCurrentCap(cap), .chargeConfigSelect(chgCfg),
        .minimumSystemVoltage(sysMin), .watchdogRestart(restart),
        .hostMode(hostMode));
    serial_host_model u_host (.clock(clock), .sdaLine(sdaLine),
        .sclDrv(sclDrv), .sdaDrv(sdaDrv));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ackOut, input logic expAck);
        logic a;
        u_host.byte_io(tx, ackOut, rx, a);
        check({7'h00, a}, {7'h00, expAck});
    endtask

    task automatic head(input logic [7:0] idx, input logic idxAck);
        u_host.start_bit();
        xfer({DEVICE_ADDR, 1'b0}, 1'b1, 1'b0);
        xfer(idx, 1'b1, idxAck);
    endtask

    // Model: power_on_configuration bit7 reloads defaults, bits 7:6 read back 0
    task automatic wr(input int idx);
        head(idx[7:0], 1'b0);
        foreach (q[k]) begin
            xfer(q[k], 1'b1, 1'b0);
            if (idx + k == 1 && q[k][7]) begin
                foreach (m[j]) if (j < 8) m[j] = RESET_VAL[j];
            end else if (idx + k < 8) begin
                m[idx+k] = (idx + k == 1) ? (q[k] & 8'h3f) : q[k];
            end
        end
        u_host.stop_bit();
    endtask

    task automatic rd(input int idx, input int n);
        head(idx[7:0], 1'b0);
        u_host.start_bit();
        xfer({DEVICE_ADDR, 1'b1}, 1'b1, 1'b0);
        for (int k = 0; k < n; k++) begin
            xfer(8'hff, k == n - 1, k == n - 1);
            check(rx, m[idx+k]);
        end
        u_host.stop_bit();
    endtask

    task automatic outs();
        check({hiz, vFloor, cap}, m[0]);
        check({3'h0, chgCfg, sysMin}, {3'h0, m[1][5:1]});
        check({5'h00, sclOut, sclOe, sdaOut}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (restart === 1'b1) wdCount++;
        if (cycles == 60000) begin
            badCount++;
            end_of_test();
        end
    end

    initial begin
        {reset, boostPin, detDone, wdExp, kind} = 6'h20;
        seed = 32'hc89a;
        {sysSt, fltSt, part} = {rnd(), rnd(), rnd()};
        foreach (m[j]) m[j] = (j < 8) ? RESET_VAL[j] : 8'h00;
        {m[8], m[9], m[10]} = {sysSt, fltSt, part};
        repeat (10) @(posedge clock);
        #1 reset = 1'b0;
        check({hiz, vFloor, cap}, 8'h30);
        check({2'b00, chgCfg, sysMin, 1'b1}, 8'h1b);
        check({7'h00, hostMode}, 8'h00);
        u_host.tick(5);
        rd(0, 8);
        q = {rnd()};
        wr(0);
        outs();
        check({7'h00, hostMode}, 8'h01);
        q = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        wr(2);
        rd(0, 8);
        q = {rnd()};
        wr(8);
        for (int i = 8; i < 11; i++) rd(i, 1);
        {sysSt, fltSt} = {rnd(), rnd()};
        {m[8], m[9]} = {sysSt, fltSt};
        rd(8, 2);
        u_host.start_bit();
        xfer({7'h6a, 1'b0}, 1'b1, 1'b1);
        u_host.stop_bit();
        head(8'h0b, 1'b1);
        u_host.stop_bit();
        head(8'h0a, 1'b0);
        xfer(rnd(), 1'b1, 1'b0);
        xfer(rnd(), 1'b1, 1'b1);
        u_host.stop_bit();
        w0 = wdCount;
        for (int i = 0; i < 2; i++) begin
            r8 = rnd();
            q = {{2'b01, r8[4:0], 1'b1}};
            wr(1);
        end
        check(wdCount[7:0], w0[7:0] + 8'h02);
        rd(1, 1);
        outs();
        for (int k = 0; k < 8; k++) begin
            boostPin = k[0];
            u_host.tick(5);
            kind = k[2:1];
            detDone = 1'b1;
            u_host.tick(1);
            detDone = 1'b0;
            if (kind != 2'b00) m[0][2:0] = (kind != 2'b01) ? 3'b101 : {1'b0, k[0], 1'b0};
            u_host.tick(1);
            check({5'h00, cap}, {5'h00, m[0][2:0]});
        end
        wdExp = 1'b1;
        u_host.tick(1);
        wdExp = 1'b0;
        u_host.tick(1);
        check({7'h00, hostMode}, 8'h00);
        r8 = rnd();
        q = {{2'b10, r8[4:0], 1'b1}};
        wr(1);
        outs();
        check({7'h00, hostMode}, 8'h01);
        rd(0, 8);
        end_of_test();
    end
endmodule // tb_top

`default_nettype wire
